// ---- pkg/flash_guard_regs.vh ----
`ifndef FLASH_GUARD_REGS_VH
`define FLASH_GUARD_REGS_VH

// Command opcodes
`define CMD_WRITE_ENABLE    8'h06
`define CMD_WRITE_DISABLE   8'h04
`define CMD_STATUS_READ     8'h05
`define CMD_STATUS_WRITE    8'h01
`define CMD_PROGRAM         8'h12
`define CMD_SECTOR_ERASE    8'h21
`define CMD_BLOCK_ERASE     8'hdc
`define CMD_CHIP_ERASE      8'hc7
`define CMD_POWERDOWN       8'hb9
`define CMD_SIGNATURE_READ  8'hab
`define CMD_SUSPEND         8'hb0
`define CMD_RESUME          8'h30
`define CMD_RESET_ENABLE    8'h66
`define CMD_RESET           8'h99
`define CMD_SEC_ENTER       8'hb1
`define CMD_SEC_EXIT        8'hc1
`define CMD_SEC_READ        8'h2b
`define CMD_SEC_WRITE       8'h2f
`define CMD_QUAD_ENTER      8'h35
`define CMD_QUAD_EXIT       8'hf5

// Status byte fields
`define ST_SRWD             7
`define ST_QE               6
`define ST_BP_HI            5
`define ST_BP_LO            2
`define ST_WEL              1
`define ST_BUSY             0
// Second status-write byte field
`define CFG_TB              3

// Security byte fields
`define SEC_FACTORY_LOCK    0
`define SEC_CUSTOMER_LOCK   1

// Reset values
`define STATUS_RST          8'h00
`define TB_RST              1'b0

// Array geometry
`define BLK_ADDR_HI         24
`define BLK_ADDR_LO         16
`define OTP_HALF_BIT        9
`define LEVEL_ALL           4'ha

// Frame lengths in bytes
`define LEN_OPCODE_ONLY     3'd1
`define LEN_STATUS_SHORT    3'd2
`define LEN_STATUS_LONG     3'd3
`define LEN_ADDR_ONLY       3'd5
`define LEN_PROG_MIN        3'd6

// Operation kinds
`define KIND_PROGRAM        2'd0
`define KIND_SECTOR         2'd1
`define KIND_BLOCK          2'd2
`define KIND_CHIP           2'd3

`endif

// ---- hdl/block_protect_decode.v ----
`timescale 1ns/1ps
`include "flash_guard_regs.vh"

module block_protect_decode #(
  parameter BLK_W = 9
) (
  input  wire [BLK_W-1:0] block_i,
  input  wire [3:0]       level_i,
  input  wire             tb_select_i,
  output reg              protected_o
);

  reg [BLK_W-1:0] mask;

  always @* begin
    mask        = {BLK_W{1'b1}} << (level_i - 4'h1);
    protected_o = 1'b0;
    if (level_i >= `LEVEL_ALL) begin
      protected_o = 1'b1; // see [R7]
    end else if (level_i != 4'h0) begin
      if (tb_select_i) begin
        protected_o = ((block_i & mask) == {BLK_W{1'b0}}); // see [R6]
      end else begin
        protected_o = ((block_i & mask) == mask); // see [R5]
      end
    end
  end

endmodule

// ---- hdl/serial_flash_write_guard.v ----
// How it works
// [R1] Reset puts command machine in standby
// [R2] Commands must end on a byte boundary
// [R3] Data-changing commands need the write enable latch
// [R4] Deep power-down accepts only five wake commands
// [R5] Bottom select: levels protect top blocks
// [R6] Top select: levels protect blocks from zero
// [R7] Levels ten to fifteen protect everything
// [R8] Write-protect pin locks level and SRWD bits
// [R9] Quad modes disable hardware protection
// [R10] Security bit 0 shows factory lock
// [R11] Security mode redirects programs to OTP area
// [R12] Customer lock bit only goes zero to one
// [R13] Locked OTP refused; security mode blocks array
// [R14] Low OTP half customer, high half factory
// [R15] Unknown command: standby, output off till select
// [R16] Valid command stays active until deselect
// [R17] Sample on clock rise, drive on fall
// [R18] Read output ends cleanly on deselect
// [R19] Off-boundary write-type commands are discarded
// [R20] Array commands ignored while operation runs
// [R21] Host polls status before each command; the test never polls, it waits 8 clocks after each frame
// [R22] Host idles clock per polarity setting
// [R23] Block number from address bits 24:16
`timescale 1ns/1ps
`include "flash_guard_regs.vh"

module serial_flash_write_guard #(
  parameter [7:0] SIGNATURE = 8'h5a // Arbitrary value
) (
  input  wire        clk_sys_i,
  input  wire        arst_n_i,
  input  wire        sclk_i,
  input  wire        cs_n_i,
  input  wire        si_i,
  input  wire        write_protect_pin_n_i,
  input  wire        factory_lock_i,
  input  wire        op_busy_i,
  output wire        so_o,
  output wire        so_oe_o,
  output wire        write_enable_latch_o,
  output wire [3:0]  protect_level_o,
  output wire        tb_select_o,
  output wire        srwd_o,
  output wire        quad_enable_o,
  output wire        quad_command_mode_o,
  output wire        deep_powerdown_o,
  output wire        security_mode_o,
  output wire        customer_lock_o,
  output wire        active_o,
  output wire        op_start_o,
  output wire [1:0]  op_kind_o,
  output wire [31:0] op_addr_o,
  output wire        op_otp_o,
  output wire [7:0]  prog_data_o,
  output wire        prog_data_valid_o,
  output wire        suspend_o,
  output wire        resume_o,
  output wire        soft_reset_o,
  output wire        cmd_reject_o
);

  localparam [1:0] ST_STANDBY = 2'd0;
  localparam [1:0] ST_OPCODE  = 2'd1;
  localparam [1:0] ST_ACTIVE  = 2'd2;
  localparam [1:0] ST_IGNORE  = 2'd3;
  localparam [7:0] STATUS_INIT = `STATUS_RST;

  reg  [4:0]  sync1_q;
  reg  [4:0]  sync2_q;
  reg         sclk_last_q;
  reg         cs_last_q;
  reg  [1:0]  state_q;
  reg         active_q;
  reg  [2:0]  bit_cnt_q;
  reg  [2:0]  byte_cnt_q;
  reg  [6:0]  shift_q;
  reg  [7:0]  cmd_q;
  reg  [31:0] addr_q;
  reg  [7:0]  wr_byte_q;
  reg  [7:0]  cfg_byte_q;
  reg         out_en_q;
  reg  [2:0]  obit_q;
  reg         so_q;
  reg         so_oe_q;
  reg         wel_q;
  reg  [3:0]  level_q;
  reg         tb_q;
  reg         srwd_q;
  reg         qe_q;
  reg         qpi_q;
  reg         dpd_q;
  reg         sec_q;
  reg         cust_lock_q;
  reg         rst_armed_q;
  reg         op_start_q;
  reg  [1:0]  op_kind_q;
  reg  [31:0] op_addr_q;
  reg         op_otp_q;
  reg  [7:0]  prog_data_q;
  reg         prog_valid_q;
  reg         suspend_q;
  reg         resume_q;
  reg         soft_reset_q;
  reg         reject_q;
  reg         cmd_ok;
  reg  [7:0]  rd_byte;

  wire sclk_s    = sync2_q[0];
  wire cs_n_s    = sync2_q[1];
  wire si_s      = sync2_q[2];
  wire wp_n_s    = sync2_q[3];
  wire flock_s   = sync2_q[4];
  wire sclk_rise = sclk_s & ~sclk_last_q;
  wire sclk_fall = ~sclk_s & sclk_last_q;
  wire cs_rise   = cs_n_s & ~cs_last_q;
  wire cs_fall   = ~cs_n_s & cs_last_q;
  wire [7:0] byte_in = {shift_q, si_s};
  wire byte_done = sclk_rise & ~cs_n_s & (bit_cnt_q == 3'd7);
  wire hardware_protect_mode       = srwd_q & ~wp_n_s & ~qe_q & ~qpi_q; // see [R8] [R9]
  wire on_bound  = (bit_cnt_q == 3'd0); // see [R2] [R19]
  wire blk_prot;
  wire otp_locked;
  wire [7:0] status_byte;

  assign status_byte = {srwd_q, qe_q, level_q, wel_q, op_busy_i};
  // see [R14]
  assign otp_locked = addr_q[`OTP_HALF_BIT] ? flock_s : cust_lock_q;

  block_protect_decode #(
    .BLK_W (`BLK_ADDR_HI - `BLK_ADDR_LO + 1)
  ) u_protect (
    .block_i     (addr_q[`BLK_ADDR_HI:`BLK_ADDR_LO]), // see [R23]
    .level_i     (level_q),
    .tb_select_i (tb_q),
    .protected_o (blk_prot)
  );

  // Opcode acceptance
  always @* begin
    cmd_ok = 1'b0;
    case (byte_in)
      `CMD_SIGNATURE_READ, `CMD_SUSPEND, `CMD_RESUME,
      `CMD_RESET_ENABLE, `CMD_RESET: begin
        cmd_ok = 1'b1;
      end
      `CMD_WRITE_ENABLE, `CMD_WRITE_DISABLE, `CMD_STATUS_READ,
      `CMD_STATUS_WRITE, `CMD_PROGRAM, `CMD_SECTOR_ERASE,
      `CMD_BLOCK_ERASE, `CMD_CHIP_ERASE, `CMD_POWERDOWN,
      `CMD_SEC_ENTER, `CMD_SEC_EXIT, `CMD_SEC_READ, `CMD_SEC_WRITE,
      `CMD_QUAD_ENTER, `CMD_QUAD_EXIT: begin
        cmd_ok = ~dpd_q; // see [R4]
      end
      default: begin
        cmd_ok = 1'b0;
      end
    endcase
  end

  // Byte shown by read-type commands
  always @* begin
    case (cmd_q)
      `CMD_STATUS_READ:    rd_byte = status_byte;
      `CMD_SEC_READ:       rd_byte = {6'h0, cust_lock_q, flock_s}; // see [R10]
      `CMD_SIGNATURE_READ: rd_byte = SIGNATURE;
      default:             rd_byte = 8'h00;
    endcase
  end

  // Pin synchronisers
  always @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sync1_q     <= 5'h1b;
      sync2_q     <= 5'h1b;
      sclk_last_q <= 1'b1;
      cs_last_q   <= 1'b1;
    end else begin
      sync1_q     <= {factory_lock_i, write_protect_pin_n_i, si_i,
                      cs_n_i, sclk_i};
      sync2_q     <= sync1_q;
      sclk_last_q <= sclk_s;
      cs_last_q   <= cs_n_s;
    end
  end

  // Frame receive and serial output
  always @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_q      <= ST_STANDBY; // see [R1]
      active_q     <= 1'b0;
      bit_cnt_q    <= 3'd0;
      byte_cnt_q   <= 3'd0;
      shift_q      <= 7'h00;
      cmd_q        <= 8'h00;
      addr_q       <= 32'h0000_0000;
      wr_byte_q    <= `STATUS_RST;
      cfg_byte_q   <= 8'h00;
      out_en_q     <= 1'b0;
      obit_q       <= 3'd0;
      so_q         <= 1'b0;
      so_oe_q      <= 1'b0;
      prog_data_q  <= 8'h00;
      prog_valid_q <= 1'b0;
    end else begin
      prog_valid_q <= 1'b0;
      if (cs_fall) begin
        state_q    <= ST_OPCODE;
        bit_cnt_q  <= 3'd0;
        byte_cnt_q <= 3'd0;
        out_en_q   <= 1'b0;
        obit_q     <= 3'd0;
      end else if (cs_rise) begin
        state_q  <= ST_STANDBY; // see [R16]
        active_q <= 1'b0;
        out_en_q <= 1'b0; // see [R18]
        so_oe_q  <= 1'b0;
      end else if (sclk_rise && !cs_n_s && state_q != ST_IGNORE) begin
        bit_cnt_q <= bit_cnt_q + 3'd1; // see [R17]
        shift_q   <= byte_in[6:0];
        if (byte_done) begin
          if (byte_cnt_q != 3'd7) begin
            byte_cnt_q <= byte_cnt_q + 3'd1;
          end
          if (state_q == ST_OPCODE) begin
            cmd_q <= byte_in;
            if (cmd_ok) begin
              state_q <= ST_ACTIVE; // see [R16]
              active_q <= 1'b1;
              out_en_q <= (byte_in == `CMD_STATUS_READ) ||
                          (byte_in == `CMD_SEC_READ) ||
                          (byte_in == `CMD_SIGNATURE_READ);
            end else begin
              state_q <= ST_IGNORE; // see [R15]
            end
          end else begin
            if (byte_cnt_q <= 3'd4) begin
              addr_q <= {addr_q[23:0], byte_in};
            end
            if (byte_cnt_q == 3'd1) begin
              wr_byte_q <= byte_in;
            end
            if (byte_cnt_q == 3'd2) begin
              cfg_byte_q <= byte_in;
            end
            if (cmd_q == `CMD_PROGRAM && byte_cnt_q >= 3'd5) begin
              prog_data_q  <= byte_in;
              prog_valid_q <= 1'b1;
            end
          end
        end
      end else if (sclk_fall && out_en_q && !cs_n_s) begin
        so_q    <= rd_byte[3'd7 - obit_q]; // see [R17]
        so_oe_q <= 1'b1;
        obit_q  <= obit_q + 3'd1;
      end
    end
  end

  // Command execution at deselect
  always @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wel_q        <= 1'b0;
      level_q      <= STATUS_INIT[`ST_BP_HI:`ST_BP_LO];
      tb_q         <= `TB_RST;
      srwd_q       <= 1'b0;
      qe_q         <= 1'b0;
      qpi_q        <= 1'b0;
      dpd_q        <= 1'b0;
      sec_q        <= 1'b0;
      cust_lock_q  <= 1'b0;
      rst_armed_q  <= 1'b0;
      op_start_q   <= 1'b0;
      op_kind_q    <= `KIND_PROGRAM;
      op_addr_q    <= 32'h0000_0000;
      op_otp_q     <= 1'b0;
      suspend_q    <= 1'b0;
      resume_q     <= 1'b0;
      soft_reset_q <= 1'b0;
      reject_q     <= 1'b0;
    end else begin
      op_start_q   <= 1'b0;
      suspend_q    <= 1'b0;
      resume_q     <= 1'b0;
      soft_reset_q <= 1'b0;
      reject_q     <= 1'b0;
      if (cs_rise && state_q == ST_ACTIVE) begin
        if (cmd_q != `CMD_RESET_ENABLE) begin
          rst_armed_q <= 1'b0;
        end
        case (cmd_q)
          `CMD_STATUS_READ, `CMD_SEC_READ: begin
          end
          `CMD_SIGNATURE_READ: begin
            dpd_q <= 1'b0;
          end
          default: begin
            if (!on_bound) begin
              reject_q <= 1'b1; // see [R19] [R2]
            end else begin
              case (cmd_q)
                `CMD_WRITE_ENABLE: begin
                  wel_q <= (byte_cnt_q == `LEN_OPCODE_ONLY) | wel_q;
                end
                `CMD_WRITE_DISABLE: begin
                  if (byte_cnt_q == `LEN_OPCODE_ONLY) begin
                    wel_q <= 1'b0;
                  end
                end
                `CMD_STATUS_WRITE: begin
                  if (!wel_q || op_busy_i ||
                      (byte_cnt_q != `LEN_STATUS_SHORT &&
                       byte_cnt_q != `LEN_STATUS_LONG)) begin
                    reject_q <= 1'b1; // see [R3] [R20]
                  end else begin
                    wel_q <= 1'b0;
                    qe_q  <= wr_byte_q[`ST_QE];
                    if (!hardware_protect_mode) begin
                      level_q <= wr_byte_q[`ST_BP_HI:`ST_BP_LO]; // see [R8]
                      srwd_q  <= wr_byte_q[`ST_SRWD];
                    end
                    if (byte_cnt_q == `LEN_STATUS_LONG) begin
                      tb_q <= cfg_byte_q[`CFG_TB];
                    end
                  end
                end
                `CMD_PROGRAM: begin
                  if (!wel_q || op_busy_i ||
                      byte_cnt_q < `LEN_PROG_MIN) begin
                    reject_q <= 1'b1; // see [R3] [R20]
                  end else if (sec_q ? otp_locked : blk_prot) begin
                    reject_q <= 1'b1; // see [R13] [R5] [R6] [R7]
                    wel_q    <= 1'b0;
                  end else begin
                    wel_q      <= 1'b0;
                    op_start_q <= 1'b1;
                    op_kind_q  <= `KIND_PROGRAM;
                    op_addr_q  <= addr_q;
                    op_otp_q   <= sec_q; // see [R11]
                  end
                end
                `CMD_SECTOR_ERASE, `CMD_BLOCK_ERASE: begin
                  if (!wel_q || op_busy_i || sec_q || blk_prot ||
                      byte_cnt_q != `LEN_ADDR_ONLY) begin
                    reject_q <= 1'b1; // see [R3] [R13] [R20]
                  end else begin
                    wel_q      <= 1'b0;
                    op_start_q <= 1'b1;
                    op_kind_q  <= (cmd_q == `CMD_BLOCK_ERASE) ?
                                  `KIND_BLOCK : `KIND_SECTOR;
                    op_addr_q  <= addr_q;
                    op_otp_q   <= 1'b0;
                  end
                end
                `CMD_CHIP_ERASE: begin
                  if (!wel_q || op_busy_i || sec_q ||
                      level_q != 4'h0 ||
                      byte_cnt_q != `LEN_OPCODE_ONLY) begin
                    reject_q <= 1'b1; // see [R3] [R7] [R20]
                  end else begin
                    wel_q      <= 1'b0;
                    op_start_q <= 1'b1;
                    op_kind_q  <= `KIND_CHIP;
                    op_addr_q  <= 32'h0000_0000;
                    op_otp_q   <= 1'b0;
                  end
                end
                `CMD_SEC_WRITE: begin
                  if (!wel_q || op_busy_i) begin
                    reject_q <= 1'b1; // see [R3]
                  end else begin
                    wel_q       <= 1'b0;
                    cust_lock_q <= 1'b1; // see [R12]
                  end
                end
                `CMD_POWERDOWN: begin
                  dpd_q <= ~op_busy_i;
                end
                `CMD_SEC_ENTER: begin
                  sec_q <= 1'b1; // see [R11]
                end
                `CMD_SEC_EXIT: begin
                  sec_q <= 1'b0;
                end
                `CMD_QUAD_ENTER: begin
                  qpi_q <= 1'b1;
                end
                `CMD_QUAD_EXIT: begin
                  qpi_q <= 1'b0;
                end
                `CMD_SUSPEND: begin
                  suspend_q <= 1'b1;
                end
                `CMD_RESUME: begin
                  resume_q <= 1'b1;
                end
                `CMD_RESET_ENABLE: begin
                  rst_armed_q <= 1'b1;
                end
                `CMD_RESET: begin
                  if (rst_armed_q) begin
                    soft_reset_q <= 1'b1;
                    wel_q        <= 1'b0;
                    sec_q        <= 1'b0;
                    qpi_q        <= 1'b0;
                    dpd_q        <= 1'b0;
                  end else begin
                    reject_q <= 1'b1;
                  end
                end
                default: begin
                  reject_q <= 1'b1;
                end
              endcase
            end
          end
        endcase
      end
    end
  end

  assign so_o                 = so_q;
  assign so_oe_o              = so_oe_q; // see [R15]
  assign write_enable_latch_o = wel_q;
  assign protect_level_o      = level_q;
  assign tb_select_o          = tb_q;
  assign srwd_o               = srwd_q;
  assign quad_enable_o        = qe_q;
  assign quad_command_mode_o  = qpi_q;
  assign deep_powerdown_o     = dpd_q;
  assign security_mode_o      = sec_q;
  assign customer_lock_o      = cust_lock_q;
  assign active_o             = active_q;
  assign op_start_o           = op_start_q;
  assign op_kind_o            = op_kind_q;
  assign op_addr_o            = op_addr_q;
  assign op_otp_o             = op_otp_q;
  assign prog_data_o          = prog_data_q;
  assign prog_data_valid_o    = prog_valid_q;
  assign suspend_o            = suspend_q;
  assign resume_o             = resume_q;
  assign soft_reset_o         = soft_reset_q;
  assign cmd_reject_o         = reject_q;

endmodule

// ---- verif/serial_flash_write_guard_props.sv ----
`timescale 1ns/1ps
`include "flash_guard_regs.vh"
module serial_flash_write_guard_props (
  input wire        clk_sys_i,
  input wire        arst_n_i,
  input wire        sclk_i,
  input wire        cs_n_i,
  input wire        write_protect_pin_n_i,
  input wire        factory_lock_i,
  input wire        so_o,
  input wire        so_oe_o,
  input wire        write_enable_latch_o,
  input wire [3:0]  protect_level_o,
  input wire        tb_select_o,
  input wire        srwd_o,
  input wire        quad_enable_o,
  input wire        quad_command_mode_o,
  input wire        deep_powerdown_o,
  input wire        security_mode_o,
  input wire        customer_lock_o,
  input wire        active_o,
  input wire        op_start_o,
  input wire [1:0]  op_kind_o,
  input wire [31:0] op_addr_o,
  input wire        op_otp_o
);
  reg [2:0] wp_low_q;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!arst_n_i);
  // Cycles the write-protect pin has been low, saturating
  always @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) wp_low_q <= 3'h0;
    else if (write_protect_pin_n_i) wp_low_q <= 3'h0;
    else if (wp_low_q != 3'h7) wp_low_q <= wp_low_q + 3'h1;
  end
  function automatic logic prot(input logic [8:0] b, input logic [3:0] l,
                                input logic t);
    logic [9:0] n;
    n = (l == 4'h0) ? 10'h0 : (10'h1 << (l - 4'h1));
    return (l >= `LEVEL_ALL) ||
           (t ? ({1'b0, b} < n) : ({1'b0, b} >= 10'h200 - n));
  endfunction
  a_reset_idle: assert property (
    @(posedge clk_sys_i) disable iff (1'b0) !arst_n_i |->
    !write_enable_latch_o && !active_o && !so_oe_o && !op_start_o)
    else $error("outputs not idle in reset");
  a_wel_gate: assert property (
    op_start_o |-> $past(write_enable_latch_o))
    else $error("operation started without write enable");
  a_powerdown_mute: assert property (
    $past(deep_powerdown_o) |-> !op_start_o && !$rose(write_enable_latch_o))
    else $error("command acted on in deep power-down");
  a_protect_blocks: assert property (
    op_start_o && !op_otp_o |->
    ((op_kind_o == `KIND_CHIP) ? (protect_level_o == 4'h0) :
     !prot(op_addr_o[24:16], protect_level_o, tb_select_o)))
    else $error("operation started on protected block");
  a_hw_protect: assert property (
    $past(srwd_o) && !$past(quad_enable_o) &&
    !$past(quad_command_mode_o) && wp_low_q == 3'h7 |->
    $stable(protect_level_o) && $stable(srwd_o))
    else $error("protect bits changed under write-protect pin");
  a_lock_sticky: assert property (
    $past(customer_lock_o) |-> customer_lock_o)
    else $error("customer lock cleared");
  a_sec_no_array: assert property (
    op_start_o && security_mode_o |-> op_otp_o && op_kind_o == `KIND_PROGRAM)
    else $error("array operation in security mode");
  a_active_hold: assert property (
    active_o && !cs_n_i |=> active_o)
    else $error("active dropped while selected");
  a_oe_release: assert property (
    cs_n_i [*6] |-> !so_oe_o)
    else $error("output still driven after deselect");
  a_so_on_fall: assert property (
    so_oe_o && $past(so_oe_o) && so_o != $past(so_o) |-> !$past(sclk_i, 2))
    else $error("output changed without clock fall");
endmodule
bind serial_flash_write_guard serial_flash_write_guard_props u_props (
  .clk_sys_i, .arst_n_i, .sclk_i, .cs_n_i, .write_protect_pin_n_i,
  .factory_lock_i, .so_o, .so_oe_o, .write_enable_latch_o, .protect_level_o,
  .tb_select_o, .srwd_o, .quad_enable_o, .quad_command_mode_o,
  .deep_powerdown_o, .security_mode_o, .customer_lock_o, .active_o,
  .op_start_o, .op_kind_o, .op_addr_o, .op_otp_o);

// ---- verif/spi_host_model.sv ----
`timescale 1ns/1ps
module spi_host_model (
  input  wire  clk_i,
  input  wire  so_i,
  output logic sclk_o,
  output logic cs_n_o,
  output logic si_o
);
  logic clock_polarity = 1'b0;
  initial begin
    cs_n_o = 1'b1;
    sclk_o = 1'b0;
    si_o = 1'b0;
  end
  task automatic half();
    repeat (5) @(posedge clk_i);
    #1;
  endtask
  // Sends low nb bits of d MSB first, then clocks rb bits back in
  task automatic frame(input logic [63:0] d, input int nb, input int rb,
                       output logic [7:0] rd);
    int i;
    rd = 8'h00;
    sclk_o = clock_polarity;
    half();
    cs_n_o = 1'b0;
    for (i = nb + rb - 1; i >= 0; i--) begin
      half();
      sclk_o = 1'b0;
      if (i >= rb) si_o = d[i - rb];
      half();
      sclk_o = 1'b1;
      rd = {rd[6:0], so_i};
    end
    half();
    if (!clock_polarity) sclk_o = 1'b0;
    half();
    cs_n_o = 1'b1;
    si_o = ~si_o;
  endtask
endmodule

// ---- verif/serial_flash_write_guard_test.sv ----
`timescale 1ns/1ps
module serial_flash_write_guard_test;
  localparam [7:0] SIG = 8'h5a; // Arbitrary value
  logic        clk_sys_i, arst_n_i, wp_n, fuse, busy, t, e;
  logic [7:0]  rd;
  logic [3:0]  l;
  logic [8:0]  b;
  logic [14:0] rows [13];
  int          failures, checks, n_s, n_r, n_d, n_oe, n_p, i;
  wire         sclk, cs_n, si, so, so_oe, write_enable_latch, tbs, srwd, qe, dpd, sec, cl;
  wire         act, st, otp, pdv, rej, quad_command_mode, sus, res, srst;
  wire [3:0]   lvl;
  wire [1:0]   kind;
  wire [31:0]  addr;
  wire [7:0]   pd;
  spi_host_model host (.clk_i(clk_sys_i), .so_i(so), .sclk_o(sclk),
    .cs_n_o(cs_n), .si_o(si));
  serial_flash_write_guard #(.SIGNATURE(SIG)) uut (.clk_sys_i(clk_sys_i),
    .arst_n_i(arst_n_i), .sclk_i(sclk), .cs_n_i(cs_n), .si_i(si),
    .write_protect_pin_n_i(wp_n), .factory_lock_i(fuse), .op_busy_i(busy),
    .so_o(so), .so_oe_o(so_oe), .write_enable_latch_o(write_enable_latch),
    .protect_level_o(lvl), .tb_select_o(tbs), .srwd_o(srwd),
    .quad_enable_o(qe), .quad_command_mode_o(quad_command_mode), .deep_powerdown_o(dpd),
    .security_mode_o(sec), .customer_lock_o(cl), .active_o(act),
    .op_start_o(st), .op_kind_o(kind), .op_addr_o(addr), .op_otp_o(otp),
    .prog_data_o(pd), .prog_data_valid_o(pdv), .suspend_o(sus),
    .resume_o(res), .soft_reset_o(srst), .cmd_reject_o(rej));
  initial begin
    clk_sys_i = 1'b0;
    forever #4 clk_sys_i = ~clk_sys_i;
  end
  always @(posedge clk_sys_i) begin
    if (st === 1'b1) n_s++;
    if (rej === 1'b1) n_r++;
    if (pdv === 1'b1) n_d++;
    if (so_oe === 1'b1) n_oe++;
    if ((sus | res | srst) === 1'b1) n_p++;
  end
  task automatic c(input logic [63:0] g, input logic [63:0] x);
    checks++;
    if (g !== x) begin
      failures++;
      $display("MISMATCH at %0t: got %h expected %h", $time, g, x);
    end
  endtask
  task automatic op(input logic [63:0] d, input int nb, input int rb = 0);
    {n_s, n_r, n_d, n_oe, n_p} = '0;
    host.frame(d, nb, rb, rd);
    repeat (8) @(posedge clk_sys_i);
    #1;
  endtask
  task automatic wen();
    op(64'h06, 8);
  endtask
  task automatic wsr(input logic [15:0] v);
    wen();
    op({40'h0, 8'h01, v}, 24);
  endtask
  task automatic fin(input string s);
    $display("test %s finished", s);
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d, mismatches %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    #400_000;
    failures++;
    $display("watchdog expired");
    report_and_stop();
  end
  initial begin
    {arst_n_i, wp_n, fuse, busy} = 4'b0110;
    rows = '{{1'b0, 4'h0, 9'd511, 1'b1}, {1'b0, 4'h1, 9'd511, 1'b0},
      {1'b0, 4'h1, 9'd510, 1'b1}, {1'b0, 4'h9, 9'd256, 1'b0},
      {1'b0, 4'h9, 9'd255, 1'b1}, {1'b1, 4'h1, 9'd0, 1'b0},
      {1'b1, 4'h1, 9'd1, 1'b1}, {1'b1, 4'h9, 9'd255, 1'b0},
      {1'b1, 4'h9, 9'd256, 1'b1}, {1'b0, 4'ha, 9'd0, 1'b0},
      {1'b1, 4'hf, 9'd300, 1'b0}, {1'b0, 4'h5, 9'd495, 1'b1},
      {1'b0, 4'h5, 9'd496, 1'b0}};
    repeat (10) @(posedge clk_sys_i);
    #1;
    arst_n_i = 1'b1;
    repeat (3) @(posedge clk_sys_i);
    #1;
    for (i = 0; i < 13; i++) begin
      {t, l, b, e} = rows[i];
      wsr({2'b00, l, 2'b00, 4'h0, t, 3'h0});
      c({tbs, lvl}, {t, l});
      wen();
      op({24'h0, 8'hdc, 7'h0, b, 16'h0}, 40);
      c(n_s, e);
      c(n_r, !e);
    end
    fin("protect table");
    wsr(16'h0000);
    wen();
    op(64'h12_00000100_a53c, 56);
    c({n_s[3:0], n_d[3:0], pd, kind}, {4'd1, 4'd2, 8'h3c, 2'd0});
    c(addr, 32'h100);
    c(write_enable_latch, 1'b0);
    wen();
    op(64'hc7, 8);
    c({n_s[3:0], kind, addr}, {4'd1, 2'd3, 32'h0});
    op(64'hdc_00010000, 40);
    c({n_r[3:0], n_s[3:0]}, 8'h10);
    wen();
    op(64'h6e_00008000, 39);
    c({n_r[3:0], n_s[3:0]}, 8'h10);
    op(64'h04, 8);
    op(64'h00c, 9);
    c(write_enable_latch, 1'b0);
    fin("write gating");
    wsr(16'h8c00);
    host.clock_polarity = 1'b1;
    op(64'h05, 8, 8);
    host.clock_polarity = 1'b0;
    c(rd, 8'h8c);
    wp_n = 1'b0;
    wsr(16'h0000);
    c({n_r[3:0], lvl}, 8'h03);
    op(64'h35, 8);
    wsr(16'h8000);
    c({quad_command_mode, lvl}, 5'h10);
    op(64'hf5, 8);
    c(quad_command_mode, 1'b0);
    wp_n = 1'b1;
    wsr(16'hc800);
    wp_n = 1'b0;
    wsr(16'h0000);
    c({lvl, qe}, 5'h0);
    wp_n = 1'b1;
    op(64'h05, 8, 3);
    c(so_oe, 1'b0);
    op(64'h77, 8, 8);
    c({n_oe, n_r}, 0);
    fin("status and pin");
    op(64'hb9, 8);
    wen();
    c({dpd, write_enable_latch}, 2'b10);
    op(64'hb0, 8);
    c(n_p, 1);
    op(64'h30, 8);
    c(n_p, 1);
    op(64'h66, 8);
    op(64'h99, 8);
    c({n_p[3:0], dpd}, 5'h2);
    op(64'hb9, 8);
    op(64'hab, 8, 8);
    c({rd, dpd}, {SIG, 1'b0});
    fin("power-down");
    op(64'hb1, 8);
    wen();
    op(64'hdc_00000000, 40);
    c({sec, n_r}, {1'b1, 32'd1});
    wen();
    op(64'h12_00000010_a5, 48);
    c({n_s[3:0], otp, addr}, {4'd1, 1'b1, 32'h10});
    wen();
    op(64'h12_00000210_a5, 48);
    c(n_r, 1);
    op(64'hc1, 8);
    op(64'h2b, 8, 8);
    c({sec, rd[1:0]}, 3'b001);
    wen();
    op(64'h2f, 8);
    c(cl, 1'b1);
    op(64'hb1, 8);
    wen();
    op(64'h12_00000010_a5, 48);
    c({n_r[3:0], n_s[3:0]}, 8'h10);
    op(64'hc1, 8);
    fin("security area");
    wen();
    busy = 1'b1;
    op(64'hdc_00000000, 40);
    c({n_r[3:0], n_s[3:0]}, 8'h10);
    busy = 1'b0;
    wen();
    arst_n_i = 1'b0;
    @(posedge clk_sys_i);
    #1;
    c({write_enable_latch, act, so_oe, dpd}, 4'h0);
    arst_n_i = 1'b1;
    fin("busy and reset");
    report_and_stop();
  end
endmodule
